// *** sram_port_pkg.sv ***
package sram_port_pkg;

  // ------------------------------------------------------------
  // Array geometry
  // ------------------------------------------------------------
  localparam int ADDR_WIDTH  = 20;          // 1,048,576 words
  localparam int DATA_WIDTH  = 18;
  localparam int LANE_WIDTH  = 9;           // Lane 0 = bits 8..0, lane 1 = bits 17..9
  localparam int LANE_COUNT  = 2;
  localparam int BURST_WIDTH = 2;           // Low address bits stepped by a burst

  // ------------------------------------------------------------
  // Encodings and reset values
  // ------------------------------------------------------------
  localparam logic [BURST_WIDTH-1:0] BURST_ONE    = 2'h1;
  localparam logic [BURST_WIDTH-1:0] BURST_START  = 2'h0;
  localparam logic [LANE_COUNT-1:0]  STROBE_NONE  = 2'h3;  // Active-low strobes, all off
  localparam logic [ADDR_WIDTH-1:0]  ADDR_RESET   = 20'h00000;
  localparam logic [DATA_WIDTH-1:0]  DATA_RESET   = 18'h00000;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_e;

  typedef struct packed {
    op_e                   op;
    logic [ADDR_WIDTH-1:0] addr;
  } cmd_s;

  localparam cmd_s CMD_RESET = '{op: OP_IDLE, addr: ADDR_RESET};

endpackage : sram_port_pkg

// *** burst_addr_counter.sv ***
`timescale 1ns/10ps
module burst_addr_counter
  import sram_port_pkg::*;
#(
  parameter int ADDR_W  = ADDR_WIDTH,
  parameter int BURST_W = BURST_WIDTH
) (
  input  wire logic              ref_clk_i,  // Clock
  input  wire logic              rst_n_i,    // Async reset, active low
  input  wire logic              en_i,       // Cycle not held
  input  wire logic              load_i,     // Load new address
  input  wire logic              linear_i,   // 1 = linear order, 0 = interleaved
  input  wire logic [ADDR_W-1:0] addr_i,     // External address
  output logic      [ADDR_W-1:0] cmd_addr_o  // Address of this cycle
);

  // ------------------------------------------------------------
  // Burst state
  // ------------------------------------------------------------
  logic [ADDR_W-1:0]  base_reg;
  logic [BURST_W-1:0] count_reg;
  logic [BURST_W-1:0] count_next;
  logic [BURST_W-1:0] low_bits;

  assign count_next = load_i ? BURST_START : BURST_W'(count_reg + BURST_ONE);

  always_comb begin
    if (linear_i) begin
      low_bits = BURST_W'(base_reg[BURST_W-1:0] + count_next);
    end else begin
      low_bits = base_reg[BURST_W-1:0] ^ count_next;
    end
  end

  // Upper bits never move: a burst wraps inside its four-word group
  assign cmd_addr_o = load_i ? addr_i : {base_reg[ADDR_W-1:BURST_W], low_bits};

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_reg  <= ADDR_RESET;
      count_reg <= BURST_START;
    end else if (en_i) begin
      if (load_i) begin
        base_reg <= addr_i;
      end
      count_reg <= count_next;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_interleave_step: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (en_i && load_i) ##1 (en_i && !load_i && !linear_i)
      |-> cmd_addr_o[BURST_W-1:0] == ($past(addr_i[BURST_W-1:0]) ^ BURST_ONE))
    else $error("interleaved burst step wrong");

  chk_linear_step: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (en_i && load_i) ##1 (en_i && !load_i && linear_i) ##1 (en_i && !load_i && linear_i)
      |-> cmd_addr_o[BURST_W-1:0] == BURST_W'($past(addr_i[BURST_W-1:0], 2) + BURST_ONE + BURST_ONE))
    else $error("linear burst step wrong");

endmodule : burst_addr_counter

// *** sram_word_array.sv ***
`timescale 1ns/10ps
module sram_word_array
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int LANE_W = LANE_WIDTH,
  parameter int LANES  = LANE_COUNT,
  parameter int DATA_W = LANE_WIDTH * LANE_COUNT
) (
  input  wire logic              ref_clk_i,  // Clock
  input  wire logic              rst_n_i,    // Async reset, active low
  input  wire logic              en_i,       // Cycle not held
  input  wire logic              rd_en_i,    // Read strobe
  input  wire logic [ADDR_W-1:0] rd_addr_i,  // Read address
  input  wire logic              wr_en_i,    // Write strobe
  input  wire logic [ADDR_W-1:0] wr_addr_i,  // Write address
  input  wire logic [DATA_W-1:0] wr_data_i,  // Write data
  input  wire logic [LANES-1:0]  wr_lane_i,  // Lane enables, active high
  output logic      [DATA_W-1:0] rd_data_o   // Registered read data
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0] words_reg [0:(2**ADDR_W)-1];
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_word;

  always_ff @(posedge ref_clk_i) begin
    if (en_i && wr_en_i) begin
      for (int l = 0; l < LANES; l++) begin
        if (wr_lane_i[l]) begin
          words_reg[wr_addr_i][l*LANE_W +: LANE_W] <= wr_data_i[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Forward a same-edge write so back-to-back write/read sees new data
  always_comb begin
    rd_word = words_reg[rd_addr_i];
    for (int l = 0; l < LANES; l++) begin
      if (wr_en_i && wr_lane_i[l] && (wr_addr_i == rd_addr_i)) begin
        rd_word[l*LANE_W +: LANE_W] = wr_data_i[l*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= DATA_RESET;
    end else if (en_i && rd_en_i) begin
      rd_data_reg <= rd_word;
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule : sram_word_array

// *** zero_turnaround_sram_port.sv ***
`timescale 1ns/10ps
module zero_turnaround_sram_port
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int LANE_W = LANE_WIDTH,
  parameter int LANES  = LANE_COUNT,
  parameter int DATA_W = LANE_WIDTH * LANE_COUNT
) (
  input  wire logic              ref_clk_i,                  // Clock
  input  wire logic              rst_n_i,                    // Async reset, active low
  input  wire logic              clock_hold_n_i,             // 1 = hold this cycle
  input  wire logic              burst_step_or_load_i,       // 1 = advance, 0 = load
  input  wire logic              read_write_sel_i,           // 1 = read, 0 = write
  input  wire logic              chip_select_first_n_i,      // Select, active low
  input  wire logic              chip_select_second_i,       // Select, active high
  input  wire logic              chip_select_third_n_i,      // Select, active low
  input  wire logic              linear_order_select_n_i,    // 0 = linear, 1 = interleaved
  input  wire logic              out_enable_n_i,             // Output enable, active low
  input  wire logic [ADDR_W-1:0] addr_i,                     // Word address
  input  wire logic [LANES-1:0]  byte_lane_write_strobe_n_i, // Lane strobes, active low
  input  wire logic [DATA_W-1:0] dq_i,                       // Lane input level
  output logic      [DATA_W-1:0] dq_o,                       // Lane drive value
  output logic                   dq_oe_o                     // Lane drive enable
);

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic              go;
  logic              load;
  logic              selected;
  op_e               op_in;
  op_e               last_op_reg;
  logic [ADDR_W-1:0] cmd_addr;
  cmd_s              cmd_in;
  cmd_s              stage1_reg;
  cmd_s              stage2_reg;
  logic              mem_we;
  logic [LANES-1:0]  mem_lane;
  logic [DATA_W-1:0] rd_data;

  assign go       = !clock_hold_n_i;
  assign load     = !burst_step_or_load_i;
  assign selected = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;

  always_comb begin
    if (!load) begin
      op_in = last_op_reg;
    end else if (!selected) begin
      op_in = OP_IDLE;
    end else if (read_write_sel_i) begin
      op_in = OP_READ;
    end else begin
      op_in = OP_WRITE;
    end
  end

  burst_addr_counter #(
    .ADDR_W  (ADDR_W),
    .BURST_W (BURST_WIDTH)
  ) u_burst (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (go),
    .load_i     (load),
    .linear_i   (!linear_order_select_n_i),
    .addr_i     (addr_i),
    .cmd_addr_o (cmd_addr)
  );

  assign cmd_in = '{op: op_in, addr: cmd_addr};

  // ------------------------------------------------------------
  // Operation memory for advance cycles
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_op_reg <= OP_IDLE;
    end else if (go && load) begin
      last_op_reg <= op_in;
    end
  end

  // ------------------------------------------------------------
  // Two-stage pipeline
  // ------------------------------------------------------------
  // Same depth for reads and writes, so the bus never turns around idle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1_reg <= CMD_RESET;
      stage2_reg <= CMD_RESET;
    end else if (go) begin
      stage1_reg <= cmd_in;
      stage2_reg <= stage1_reg;
    end
  end

  // ------------------------------------------------------------
  // Array access
  // ------------------------------------------------------------
  // Strobes come with the data beat, so a write abort costs no array cycle
  assign mem_lane = ~byte_lane_write_strobe_n_i;
  assign mem_we   = (stage2_reg.op == OP_WRITE) && (byte_lane_write_strobe_n_i != STROBE_NONE);

  sram_word_array #(
    .ADDR_W (ADDR_W),
    .LANE_W (LANE_W),
    .LANES  (LANES),
    .DATA_W (DATA_W)
  ) u_array (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .en_i      (go),
    .rd_en_i   (stage1_reg.op == OP_READ),
    .rd_addr_i (stage1_reg.addr),
    .wr_en_i   (mem_we),
    .wr_addr_i (stage2_reg.addr),
    .wr_data_i (dq_i),
    .wr_lane_i (mem_lane),
    .rd_data_o (rd_data)
  );

  // ------------------------------------------------------------
  // Lane drivers
  // ------------------------------------------------------------
  assign dq_o = rd_data;
  // Output enable bypasses the clock; writes never need it toggled
  assign dq_oe_o = (stage2_reg.op == OP_READ) && !out_enable_n_i;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence seq_read_load;
    go && load && selected && read_write_sel_i;
  endsequence

  sequence seq_write_load;
    go && load && selected && !read_write_sel_i;
  endsequence

  sequence seq_desel_load;
    go && load && !selected;
  endsequence

  chk_read_latency: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_read_load ##1 go |=> (stage2_reg.op == OP_READ) && (dq_oe_o == !out_enable_n_i))
    else $error("read data not on lanes two clocks after command");

  chk_write_capture: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_write_load ##1 go ##1 go |-> mem_we == (byte_lane_write_strobe_n_i != STROBE_NONE))
    else $error("write data not captured two clocks after command");

  chk_write_no_oe: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (seq_write_load and !out_enable_n_i) ##1 (go && !out_enable_n_i) ##1 (go && !out_enable_n_i)
      |-> !dq_oe_o && (stage2_reg.op == OP_WRITE))
    else $error("write cycle drove the lanes");

  chk_deselect_float: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_desel_load ##1 go |=> !dq_oe_o)
    else $error("lanes driven after deselect");

  chk_pipe_drain: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_read_load ##1 seq_desel_load |=> stage2_reg.op == OP_READ)
    else $error("deselect cut off pending read");

  chk_hold_freeze: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !go |=> $stable(stage1_reg) && $stable(stage2_reg) && $stable(dq_o) && $stable(last_op_reg))
    else $error("state moved during clock hold");

  chk_oe_async: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    out_enable_n_i |-> !dq_oe_o)
    else $error("lanes driven with output enable off");

  chk_advance_ignore: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    go && !load |=> stage1_reg.op == $past(last_op_reg))
    else $error("advance cycle did not continue last operation");

  chk_write_abort: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (byte_lane_write_strobe_n_i == STROBE_NONE) |-> !mem_we)
    else $error("array written with all strobes off");

  // ------------------------------------------------------------
  // Pipeline and burst checks
  // ------------------------------------------------------------
  sequence seq_advance;
    go && !load;
  endsequence

  chk_load_addr: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    go && load |=> stage1_reg.addr == $past(addr_i))
    else $error("load address not captured on command edge");

  chk_load_op: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    go && load && selected |=> stage1_reg.op == ($past(read_write_sel_i) ? OP_READ : OP_WRITE))
    else $error("load operation not captured on command edge");

  chk_desel_idle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_desel_load |=> stage1_reg.op == OP_IDLE)
    else $error("deselect load started an operation");

  chk_lanes_idle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    stage2_reg.op != OP_READ |-> !dq_oe_o)
    else $error("lanes driven without a read in the output stage");

  chk_desel_no_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_desel_load ##1 go ##1 go |-> !mem_we)
    else $error("array written after deselect");

  chk_stage_shift: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    go |=> stage2_reg == $past(stage1_reg))
    else $error("pipeline did not advance one stage");

  chk_write_drain: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_write_load ##1 seq_desel_load |=> stage2_reg.op == OP_WRITE)
    else $error("deselect cut off pending write");

  chk_burst_upper: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_advance |=> stage1_reg.addr[ADDR_W-1:BURST_WIDTH] == $past(stage1_reg.addr[ADDR_W-1:BURST_WIDTH]))
    else $error("advance cycle followed the external address");

  chk_read_burst: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_read_load ##1 seq_advance |=> stage1_reg.op == OP_READ)
    else $error("read burst not continued");

  chk_write_burst: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_write_load ##1 seq_advance |=> stage1_reg.op == OP_WRITE)
    else $error("write burst not continued");

  chk_desel_burst: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_desel_load ##1 seq_advance |=> stage1_reg.op == OP_IDLE)
    else $error("deselect burst not continued");

  chk_last_op_keep: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_advance |=> $stable(last_op_reg))
    else $error("advance cycle changed the remembered operation");

  chk_hold_delay: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_read_load ##1 !go ##1 go |=> stage2_reg.op == OP_READ)
    else $error("held cycle lost a pending read");

  chk_oe_enable: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (stage2_reg.op == OP_READ) && !out_enable_n_i |-> dq_oe_o)
    else $error("read beat not driven with output enable on");

  chk_full_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (stage2_reg.op == OP_WRITE) && (byte_lane_write_strobe_n_i == '0) |-> mem_we && (&mem_lane))
    else $error("full word write missed a lane");

  chk_rdreg_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    go && (stage1_reg.op != OP_READ) |=> $stable(dq_o))
    else $error("read register moved without a read");

  chk_read_no_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_read_load ##1 go ##1 go |-> !mem_we)
    else $error("array written in a read data cycle");

  chk_mix_no_gap: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    seq_write_load ##1 seq_read_load |=> (stage1_reg.op == OP_READ) && (stage2_reg.op == OP_WRITE))
    else $error("write then read needed an idle cycle");

endmodule : zero_turnaround_sram_port

// *** sram_master_model.sv ***
`timescale 1ns/10ps
module sram_master_model
  import sram_port_pkg::*;
(
  input  wire logic                  ref_clk_i,      // Clock
  input  wire logic                  rst_n_i,        // Reset, active low
  input  wire logic                  clock_hold_n_i, // 1 = held edge
  input  wire logic                  wr_i,           // Command is a write
  input  wire logic [DATA_WIDTH-1:0] wdata_i,        // Data of that command
  input  wire logic [LANE_COUNT-1:0] strb_n_i,       // Strobes of that command
  output logic      [DATA_WIDTH-1:0] dq_o,           // Lane level to device
  output logic      [LANE_COUNT-1:0] strb_n_o        // Strobes to device
);
  // ------------------------------------------------------------
  // Two-beat data delay
  // ------------------------------------------------------------
  logic [1:0]            wr_reg;
  logic [DATA_WIDTH-1:0] d1_reg;
  logic [DATA_WIDTH-1:0] d2_reg;
  logic [LANE_COUNT-1:0] s1_reg;
  logic [LANE_COUNT-1:0] s2_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= 2'h0;
      d1_reg <= DATA_RESET;
      d2_reg <= DATA_RESET;
      s1_reg <= STROBE_NONE;
      s2_reg <= STROBE_NONE;
    end else if (!clock_hold_n_i) begin
      wr_reg <= {wr_reg[0], wr_i};
      d1_reg <= wdata_i;
      d2_reg <= d1_reg;
      s1_reg <= strb_n_i;
      s2_reg <= s1_reg;
    end
  end

  // Idle lanes show the inverse, so stale data never matches
  assign dq_o     = wr_reg[1] ? d2_reg : ~d2_reg;
  assign strb_n_o = s2_reg;
endmodule : sram_master_model

// *** test_zero_turnaround_sram_port.sv ***
`timescale 1ns/10ps
module test_zero_turnaround_sram_port
  import sram_port_pkg::*;
;
  logic                  ref_clk, rst_n, hold, adv, rw, cs1_n, cs2, cs3_n;
  logic                  lin_n, oe_n, wr, dq_oe, cur_ln, lin_r;
  logic [ADDR_WIDTH-1:0] addr, base;
  logic [DATA_WIDTH-1:0] wdata, dq_in, dq_out, p0_d, p1_d;
  logic [LANE_COUNT-1:0] strb_n, strb_dut;
  logic [1:0]            cnt;
  logic [31:0]           seed = 32'h268b1d0a;
  logic [31:0]           r, q;
  logic [DATA_WIDTH-1:0] mem [logic [ADDR_WIDTH-1:0]];
  op_e                   last_op, p0_op, p1_op;
  int                    fails = 0;
  int                    n_tests = 0;
  localparam logic [ADDR_WIDTH-1:0] TOP = 20'hfffe0;

  zero_turnaround_sram_port u_zero_turnaround_sram_port (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .clock_hold_n_i(hold), .burst_step_or_load_i(adv),
    .read_write_sel_i(rw), .chip_select_first_n_i(cs1_n), .chip_select_second_i(cs2),
    .chip_select_third_n_i(cs3_n), .linear_order_select_n_i(lin_n), .out_enable_n_i(oe_n),
    .addr_i(addr), .byte_lane_write_strobe_n_i(strb_dut), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe));

  sram_master_model u_sram_master_model (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .clock_hold_n_i(hold), .wr_i(wr),
    .wdata_i(wdata), .strb_n_i(strb_n), .dq_o(dq_in), .strb_n_o(strb_dut));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function logic [ADDR_WIDTH-1:0] step_addr(input logic [ADDR_WIDTH-1:0] a, input logic [1:0] n, input logic lin);
    return {a[ADDR_WIDTH-1:2], lin ? a[1:0] + n : a[1:0] ^ n};
  endfunction : step_addr

  function logic [DATA_WIDTH-1:0] merge(input logic [DATA_WIDTH-1:0] o, d, input logic [1:0] sb);
    return {sb[1] ? o[17:9] : d[17:9], sb[0] ? o[8:0] : d[8:0]};
  endfunction : merge

  task chk(input string what, input logic [DATA_WIDTH-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // One bus cycle; sel 0 selects, 1..3 drops one chip select
  task cyc(input logic h, a, rd, input logic [1:0] sel, input logic [ADDR_WIDTH-1:0] ad,
           input logic [DATA_WIDTH-1:0] d, input logic [1:0] sb, input logic ln, o);
    op_e                   op;
    logic [ADDR_WIDTH-1:0] ea;
    logic [DATA_WIDTH-1:0] nd;
    hold = h;
    adv = a;
    rw = rd;
    addr = ad;
    wdata = d;
    strb_n = sb;
    lin_n = ln;
    oe_n = o;
    cs1_n = (sel == 2'h1);
    cs2 = (sel != 2'h2);
    cs3_n = (sel == 2'h3);
    op = last_op;
    nd = DATA_RESET;
    if (!h && a) cnt = cnt + 2'h1;
    if (!h && !a) begin
      op = (sel != 2'h0) ? OP_IDLE : rd ? OP_READ : OP_WRITE;
      base = ad;
      cnt = 2'h0;
      lin_r = ln;
      last_op = op;
    end
    ea = step_addr(base, cnt, !lin_r);
    wr = !h && op == OP_WRITE;
    if (wr) mem[ea] = merge(mem[ea], d, sb);
    if (!h && op == OP_READ) nd = mem[ea];
    @(negedge ref_clk);
    chk("lane enable", {17'h0, dq_oe}, {17'h0, p1_op == OP_READ && !oe_n});
    if (p1_op == OP_READ) chk("read data", dq_out, p1_d);
    @(posedge ref_clk);
    if (!h) begin
      p1_op = p0_op;
      p1_d = p0_d;
      p0_op = op;
      p0_d = nd;
    end
    #1;
  endtask : cyc

  // ------------------------------------------------------------
  // Clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #1000000;
    fails++;
    finish_test();
  end

  initial begin
    {hold, adv, rw, cs1_n, cs3_n, lin_n, oe_n, wr, cnt} = '0;
    cs2 = 1'b1;
    addr = ADDR_RESET;
    wdata = DATA_RESET;
    strb_n = STROBE_NONE;
    base = ADDR_RESET;
    last_op = OP_IDLE;
    p0_op = OP_IDLE;
    p1_op = OP_IDLE;
    {p0_d, p1_d} = '0;
    {lin_r, cur_ln} = 2'h3;
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    // Fill the top 32 words with linear write bursts, output enable low
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      cyc(1'b0, i % 4 != 0, 1'b0, 2'h0, (i % 4 != 0) ? r[19:0] : TOP | i[4:0], r[31:14], 2'h0, 1'b0, 1'b0);
    end
    // Write then read at once, lane writes, abort, held cycle
    cyc(1'b0, 1'b0, 1'b0, 2'h0, TOP, 18'h2aaaa, 2'h0, 1'b1, 1'b0);
    cyc(1'b0, 1'b0, 1'b1, 2'h0, TOP, 18'h00000, 2'h3, 1'b1, 1'b0);
    cyc(1'b0, 1'b0, 1'b0, 2'h0, TOP, 18'h15555, 2'h1, 1'b1, 1'b0);
    cyc(1'b1, 1'b0, 1'b0, 2'h1, 20'h00000, 18'h3ffff, 2'h0, 1'b0, 1'b0);
    cyc(1'b0, 1'b0, 1'b1, 2'h0, TOP, 18'h00000, 2'h0, 1'b1, 1'b0);
    cyc(1'b0, 1'b0, 1'b0, 2'h0, TOP, 18'h3ffff, 2'h3, 1'b1, 1'b0);
    cyc(1'b0, 1'b0, 1'b1, 2'h0, TOP, 18'h00000, 2'h2, 1'b1, 1'b0);
    // Random mix of loads, bursts, holds, deselects and strobes
    for (int i = 0; i < 3000; i++) begin
      r = rnd();
      q = rnd();
      if (r[4:3] != 2'h0 && !r[1]) cur_ln = r[2];
      cyc(r[4:3] == 2'h0, r[1], r[10], (r[7:6] == 2'h0) ? r[9:8] : 2'h0,
          r[1] ? q[19:0] : {TOP[19:5], q[4:0]}, q[31:14], r[12:11], cur_ln, r[15:13] == 3'h0);
    end
    finish_test();
  end
endmodule : test_zero_turnaround_sram_port
